// >>> rtl/bch_cfg.svh
`ifndef BCH_CFG_SVH
`define BCH_CFG_SVH
// Register byte offsets
`define BCH_OFS_CTRL      8'h00
`define BCH_OFS_JOB       8'h04
`define BCH_OFS_ESR       8'h08
`define BCH_OFS_ESE       8'h0C
`define BCH_OFS_STAT      8'h10
// Control register fields
`define BCH_CTRL_MODE_BIT 0
`define BCH_CTRL_CTL_LSB  8
`define BCH_CTRL_OWN_LSB  16
// Job register fields
`define BCH_JOB_KIND_LSB  0
`define BCH_JOB_PTS_LSB   8
// Event status bit that asks for active control
`define BCH_ESR_RAC_BIT   1
// Status byte bit that summarises enabled events
`define BCH_STB_ESB_BIT   5
// Reset values
`define BCH_RST_CTL_ADDR  5'h15
`define BCH_RST_OWN_ADDR  5'h10
`define BCH_RST_ESE       8'h00
// Bus command bytes
`define BCH_CMD_TCT       8'h09
`define BCH_CMD_TAG_BASE  8'h40
`define BCH_CMD_UNT       8'h5F
// Job kinds
`define BCH_JOB_PLOT      2'h0
`define BCH_JOB_PRINT     2'h1
`define BCH_JOB_PMETER    2'h2
`define BCH_JOB_DISC      2'h3
`endif

// >>> rtl/bch_pkg.sv
package bch_pkg;
  // Handoff sequencer states
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,  // Not in charge, nothing pending
    ST_WAIT_CTL = 3'b001,  // Control requested, waiting for grant
    ST_ACTIVE   = 3'b010,  // In charge, peripheral job running
    ST_RET_TALK = 3'b011,  // Returning: address controller as talker
    ST_RET_TCT  = 3'b100,  // Returning: take-control command
    ST_HELD     = 3'b101   // Control kept (talker/listener mode)
  } bch_state_type;
endpackage : bch_pkg

// >>> rtl/bch_handoff.sv
`timescale 1ns/1ps
`include "bch_cfg.svh"
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module bch_handoff (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        ARST_N,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [7:0]  HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // Bus commands heard while not in charge
  input  wire logic        BUS_CMD_VLD,
  input  wire logic [7:0]  BUS_CMD,
  // Bus commands sent while in charge
  output logic             CIC_CMD_VLD,
  output logic      [7:0]  CIC_CMD,
  input  wire logic        CIC_CMD_RDY,
  output logic             CIC_ACTIVE,
  // Reserved system-controller lines
  output logic             IFC_OE,
  output logic             REN_OE,
  // Peripheral job engine
  output logic             PERIPH_GO,
  output logic      [1:0]  PERIPH_JOB,
  input  wire logic        PERIPH_DONE,
  // Front panel and status byte
  input  wire logic        FP_REQ,
  input  wire logic [1:0]  FP_JOB,
  output logic             STB_ESB
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bch_pkg::bch_state_type state_q, state_d;   // Handoff sequencer
  logic        mode_q,     mode_d;            // 1 = handoff mode
  logic [4:0]  ctl_addr_q, ctl_addr_d;        // Controller bus address
  logic [4:0]  own_addr_q, own_addr_d;        // Our bus address
  logic [7:0]  ese_q,      ese_d;             // Event enable mask
  logic        rac_q,      rac_d;             // Request-control event
  logic        talker_q,   talker_d;          // Addressed as talker
  logic [1:0]  job_q,      job_d;             // Pending job kind
  logic [7:0]  pts_q,      pts_d;             // Control requests left
  logic        go_q,       go_d;              // Job start pulse
  logic        cvld_q,     cvld_d;            // Outgoing command valid
  logic [7:0]  cmd_q,      cmd_d;             // Outgoing command byte
  logic        wr_q,       wr_d;              // Write data phase pending
  logic [7:0]  wa_q,       wa_d;              // Write address
  logic [31:0] rd_q,       rd_d;              // Read data

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  logic       acc;        // Address phase accepted
  logic       grant;      // Take-control addressed to us
  logic       job_wr;     // Software job request
  logic       new_job;    // Any job request this cycle
  logic [1:0] new_kind;   // Its kind
  logic       in_charge;  // We hold active control

  assign acc       = HSEL && HREADY && HTRANS[1];
  assign job_wr    = wr_q && (wa_q == `BCH_OFS_JOB);
  assign new_job   = job_wr || FP_REQ;
  assign new_kind  = job_wr ? HWDATA[`BCH_JOB_KIND_LSB +: 2] : FP_JOB;
  assign grant     = BUS_CMD_VLD && (BUS_CMD == `BCH_CMD_TCT) && talker_q;
  assign in_charge = (state_q == bch_pkg::ST_ACTIVE) || (state_q == bch_pkg::ST_RET_TALK)
                  || (state_q == bch_pkg::ST_RET_TCT) || (state_q == bch_pkg::ST_HELD);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_d    = state_q;
    mode_d     = mode_q;
    ctl_addr_d = ctl_addr_q;
    own_addr_d = own_addr_q;
    ese_d      = ese_q;
    rac_d      = rac_q;
    talker_d   = talker_q;
    job_d      = job_q;
    pts_d      = pts_q;
    go_d       = 1'b0;
    cvld_d     = cvld_q;
    cmd_d      = cmd_q;
    wr_d       = acc && HWRITE;
    wa_d       = acc ? HADDR : wa_q;
    rd_d       = rd_q;
    // Register writes land in the data phase
    if (wr_q) begin
      if (wa_q == `BCH_OFS_CTRL) begin
        mode_d     = HWDATA[`BCH_CTRL_MODE_BIT];
        ctl_addr_d = HWDATA[`BCH_CTRL_CTL_LSB +: 5];
        own_addr_d = HWDATA[`BCH_CTRL_OWN_LSB +: 5];
      end else if (wa_q == `BCH_OFS_ESE) begin
        ese_d = HWDATA[7:0];
      end else if (wa_q == `BCH_OFS_ESR) begin
        // Write one to clear; a set in the same cycle wins below
        if (HWDATA[`BCH_ESR_RAC_BIT]) begin
          rac_d = 1'b0;
        end
      end
    end
    // Track talker addressing from commands we hear
    if (BUS_CMD_VLD) begin
      if (BUS_CMD == (`BCH_CMD_TAG_BASE | {3'b000, own_addr_q})) begin
        talker_d = 1'b1;
      end else if ((BUS_CMD[7:5] == 3'b010) || (BUS_CMD == `BCH_CMD_UNT)) begin
        talker_d = 1'b0;
      end
    end
    // Handoff sequencer
    case (state_q)
      bch_pkg::ST_IDLE: begin
        if (grant && !mode_q) begin
          state_d = bch_pkg::ST_HELD;
        end else if (grant) begin
          state_d  = bch_pkg::ST_RET_TALK;
          cvld_d   = 1'b1;
          cmd_d    = `BCH_CMD_TAG_BASE | {3'b000, ctl_addr_q};
          talker_d = 1'b0;
        end else if (new_job && mode_q) begin
          state_d = bch_pkg::ST_WAIT_CTL;
          rac_d   = 1'b1;
          job_d   = new_kind;
          pts_d   = 8'h01;
          if (job_wr && (new_kind == `BCH_JOB_PMETER)
              && (HWDATA[`BCH_JOB_PTS_LSB +: 8] != 8'h00)) begin
            pts_d = HWDATA[`BCH_JOB_PTS_LSB +: 8];
          end
        end
      end
      bch_pkg::ST_WAIT_CTL: begin
        rac_d = 1'b1;
        if (grant) begin
          state_d  = bch_pkg::ST_ACTIVE;
          go_d     = 1'b1;
          rac_d    = 1'b0;
          talker_d = 1'b0;
        end
      end
      bch_pkg::ST_ACTIVE: begin
        // The job engine addresses and talks to peripherals itself
        if (PERIPH_DONE) begin
          state_d = bch_pkg::ST_RET_TALK;
          cvld_d  = 1'b1;
          cmd_d   = `BCH_CMD_TAG_BASE | {3'b000, ctl_addr_q};
          pts_d   = pts_q - 8'h01;
        end
      end
      bch_pkg::ST_RET_TALK: begin
        if (CIC_CMD_RDY) begin
          state_d = bch_pkg::ST_RET_TCT;
          cmd_d   = `BCH_CMD_TCT;
        end
      end
      bch_pkg::ST_RET_TCT: begin
        if (CIC_CMD_RDY) begin
          cvld_d  = 1'b0;
          state_d = (pts_q != 8'h00) ? bch_pkg::ST_WAIT_CTL : bch_pkg::ST_IDLE;
          rac_d   = (pts_q != 8'h00);
        end
      end
      bch_pkg::ST_HELD: begin
        // Kept until handoff mode is selected again
        if (mode_q) begin
          state_d = bch_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = bch_pkg::ST_IDLE;
      end
    endcase
    // Read data captured in the address phase; CTRL, ESR and ESE from next values so that a
    // write whose data phase ends at this edge is already seen (STAT from current values)
    if (acc && !HWRITE) begin
      if (HADDR == `BCH_OFS_CTRL) begin
        rd_d = {11'h000, own_addr_d, 3'h0, ctl_addr_d, 7'h00, mode_d};
      end else if (HADDR == `BCH_OFS_ESR) begin
        rd_d = {30'h0000_0000, rac_d, 1'b0};
      end else if (HADDR == `BCH_OFS_ESE) begin
        rd_d = {24'h00_0000, ese_d};
      end else if (HADDR == `BCH_OFS_STAT) begin
        rd_d = {16'h0000, pts_q, 1'b0, talker_q, job_q, in_charge, state_q};
      end else begin
        rd_d = 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q    <= bch_pkg::ST_IDLE;
      mode_q     <= 1'b0;
      ctl_addr_q <= `BCH_RST_CTL_ADDR;
      own_addr_q <= `BCH_RST_OWN_ADDR;
      ese_q      <= `BCH_RST_ESE;
      rac_q      <= 1'b0;
      talker_q   <= 1'b0;
      job_q      <= 2'h0;
      pts_q      <= 8'h00;
      go_q       <= 1'b0;
      cvld_q     <= 1'b0;
      cmd_q      <= 8'h00;
      wr_q       <= 1'b0;
      wa_q       <= 8'h00;
      rd_q       <= 32'h0000_0000;
    end else begin
      state_q    <= state_d;
      mode_q     <= mode_d;
      ctl_addr_q <= ctl_addr_d;
      own_addr_q <= own_addr_d;
      ese_q      <= ese_d;
      rac_q      <= rac_d;
      talker_q   <= talker_d;
      job_q      <= job_d;
      pts_q      <= pts_d;
      go_q       <= go_d;
      cvld_q     <= cvld_d;
      cmd_q      <= cmd_d;
      wr_q       <= wr_d;
      wa_q       <= wa_d;
      rd_q       <= rd_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign HRDATA      = rd_q;
  assign HREADYOUT   = 1'b1;     // Zero wait states
  assign HRESP       = 1'b0;
  assign CIC_CMD_VLD = cvld_q;
  assign CIC_CMD     = cmd_q;
  assign CIC_ACTIVE  = in_charge;
  assign IFC_OE      = 1'b0;
  assign REN_OE      = 1'b0;
  assign PERIPH_GO   = go_q;
  assign PERIPH_JOB  = job_q;
  assign STB_ESB     = |({6'h00, rac_q, 1'b0} & ese_q);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_req_set;
    @(posedge REF_CLK) disable iff (!ARST_N)
    (state_q == bch_pkg::ST_IDLE && mode_q && new_job && !grant) |=> rac_q;
  endproperty
  a_req_set: assert property (p_req_set) else $error("request bit not set");

  property p_fp_req;
    @(posedge REF_CLK) disable iff (!ARST_N)
    (state_q == bch_pkg::ST_IDLE && mode_q && FP_REQ && !grant)
      |=> (state_q == bch_pkg::ST_WAIT_CTL) && (job_q == $past(FP_JOB) || $past(job_wr));
  endproperty
  a_fp_req: assert property (p_fp_req) else $error("front panel request lost");

  property p_grant;
    @(posedge REF_CLK) disable iff (!ARST_N)
    (state_q == bch_pkg::ST_WAIT_CTL && grant) |=> PERIPH_GO && CIC_ACTIVE && !rac_q;
  endproperty
  a_grant: assert property (p_grant) else $error("grant not taken");

  property p_return;
    @(posedge REF_CLK) disable iff (!ARST_N)
    (state_q == bch_pkg::ST_ACTIVE && PERIPH_DONE)
      |=> CIC_CMD_VLD && (CIC_CMD == (`BCH_CMD_TAG_BASE | {3'b000, ctl_addr_q}));
  endproperty
  a_return: assert property (p_return) else $error("control not returned");

  property p_early;
    @(posedge REF_CLK) disable iff (!ARST_N)
    (state_q == bch_pkg::ST_IDLE && mode_q && grant) |=> !PERIPH_GO && CIC_CMD_VLD;
  endproperty
  a_early: assert property (p_early) else $error("early grant not bounced");

  property p_tct;
    @(posedge REF_CLK) disable iff (!ARST_N)
    (state_q == bch_pkg::ST_RET_TALK && CIC_CMD_RDY) |=> CIC_CMD == `BCH_CMD_TCT;
  endproperty
  a_tct: assert property (p_tct) else $error("take-control not sent");

  property p_sweep;
    @(posedge REF_CLK) disable iff (!ARST_N)
    (state_q == bch_pkg::ST_RET_TCT && CIC_CMD_RDY && pts_q != 8'h00) |=> rac_q;
  endproperty
  a_sweep: assert property (p_sweep) else $error("next point not requested");

  property p_held;
    @(posedge REF_CLK) disable iff (!ARST_N)
    (state_q == bch_pkg::ST_IDLE && !mode_q && grant) |=> CIC_ACTIVE && !CIC_CMD_VLD;
  endproperty
  a_held: assert property (p_held) else $error("control returned in talker mode");

  property p_lines;
    @(posedge REF_CLK) disable iff (!ARST_N)
    CIC_ACTIVE |-> !IFC_OE && !REN_OE;
  endproperty
  a_lines: assert property (p_lines) else $error("reserved line driven");

endmodule : bch_handoff

// >>> sim/bch_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host system controller on the far side of the handoff block
// ----------------------------------------------------------------
module bch_host_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Grant request from the sequence, and the device's talk address to send first
  input  wire logic       grant,
  input  wire logic [7:0] talk_cmd,
  input  wire logic       slow,
  // Command bytes toward the device
  output logic            bus_cmd_vld,
  output logic      [7:0] bus_cmd,
  // Command bytes from the device while it is in charge
  input  wire logic       cic_cmd_vld,
  input  wire logic [7:0] cic_cmd,
  output logic            cic_cmd_rdy,
  // Last two bytes taken and count of returns of control
  output logic      [7:0] prev_byte,
  output logic      [7:0] last_byte,
  output int              ret_n
);
  logic [1:0] step; // Position in the grant sequence

  // Grant is two bytes: talk address, then take-control
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step        <= 2'd0;
      bus_cmd_vld <= 1'b0;
      bus_cmd     <= 8'h00;
      cic_cmd_rdy <= 1'b0;
      prev_byte   <= 8'h00;
      last_byte   <= 8'h00;
      ret_n       <= 0;
    end else begin
      step        <= grant ? 2'd1 : 2'd0;
      bus_cmd_vld <= grant || step == 2'd1;
      if (grant) begin
        bus_cmd <= talk_cmd;
      end else if (step == 2'd1) begin
        bus_cmd <= 8'h09;
      end else begin
        bus_cmd <= ~bus_cmd; // Idle lines never hold a stale byte
      end
      // Slow mode accepts only every other cycle
      cic_cmd_rdy <= slow ? ~cic_cmd_rdy : 1'b1;
      if (cic_cmd_vld && cic_cmd_rdy) begin
        prev_byte <= last_byte;
        last_byte <= cic_cmd;
        // Take-control back to us counts as one return of control
        if (cic_cmd == 8'h09) begin
          ret_n <= ret_n + 1;
        end
      end
    end
  end
endmodule : bch_host_model

// >>> sim/test_bch_handoff.sv
`timescale 1ns/1ps
`include "bch_cfg.svh"
module test_bch_handoff;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk = 1'b0, arst_n = 1'b0;           // Clock, reset
  logic        hsel = 1'b0, hwrite = 1'b0, hready, hresp;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] hwdata = 32'h0000_0000, hrdata, rd;
  logic        bvld, cvld, crdy, cact, ifc, ren, pgo, esb;
  logic        done = 1'b0, fpr = 1'b0, hgo = 1'b0, slow = 1'b0;
  logic [7:0]  bcmd, ccmd, pbyte, lbyte;
  logic [1:0]  pjob, job_seen, fpj = 2'h0;
  int          ret_n, go_n = 0, checked = 0, mismatches = 0, cycles = 0;

  always #2 clk = ~clk;

  bch_handoff DUT (.REF_CLK(clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .BUS_CMD_VLD(bvld),
    .BUS_CMD(bcmd), .CIC_CMD_VLD(cvld), .CIC_CMD(ccmd), .CIC_CMD_RDY(crdy),
    .CIC_ACTIVE(cact), .IFC_OE(ifc), .REN_OE(ren), .PERIPH_GO(pgo), .PERIPH_JOB(pjob),
    .PERIPH_DONE(done), .FP_REQ(fpr), .FP_JOB(fpj), .STB_ESB(esb));

  bch_host_model HOST (.clk(clk), .rst_n(arst_n), .grant(hgo), .talk_cmd(8'h50),
    .slow(slow), .bus_cmd_vld(bvld), .bus_cmd(bcmd), .cic_cmd_vld(cvld),
    .cic_cmd(ccmd), .cic_cmd_rdy(crdy), .prev_byte(pbyte), .last_byte(lbyte),
    .ret_n(ret_n));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  // One AHB single transfer; read data lands in rd
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? wd : ~hwdata;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
  endtask : ahb

  // Wait for the summary bit, then confirm the request bit itself
  task automatic poll();
    while (esb !== 1'b1) @(posedge clk);
    ahb(1'b0, `BCH_OFS_ESR, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
  endtask : poll

  task automatic grant();
    @(posedge clk);
    hgo <= 1'b1;
    @(posedge clk);
    hgo <= 1'b0;
  endtask : grant

  // Grant control, finish the job if one starts, then check the return
  task automatic serve(input logic [1:0] job, input logic go_exp, input logic [7:0] ctl);
    int g0, r0;
    g0 = go_n;
    r0 = ret_n;
    grant();
    if (go_exp) begin
      // Start pulse seen at this edge; done is driven on the same edge
      while (pgo !== 1'b1) @(posedge clk);
      chk(cact, 1'b1);
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
    end
    while (ret_n == r0) @(posedge clk);
    @(posedge clk);
    #1;
    if (go_exp) chk(job_seen, job);
    chk(pbyte, `BCH_CMD_TAG_BASE | ctl);
    chk(lbyte, `BCH_CMD_TCT);
    chk(cact, 1'b0);
    chk(go_n - g0, go_exp);
  endtask : serve

  // ----------------------------------------------------------------
  // Watchers: job starts, reserved lines, hang limit
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (pgo === 1'b1) begin
      go_n++;
      job_seen = pjob;
    end
    if (ifc !== 1'b0 || ren !== 1'b0) chk(32'h0000_0001, 32'h0000_0000);
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int r0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    ahb(1'b0, `BCH_OFS_CTRL, 32'h0000_0000);
    chk(rd, 32'h0010_1500);
    ahb(1'b0, `BCH_OFS_ESE, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    ahb(1'b1, 8'h20, 32'hFFFF_FFFF);
    ahb(1'b0, 8'h20, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    ahb(1'b1, `BCH_OFS_ESR, 32'h0000_0002);
    ahb(1'b1, `BCH_OFS_ESE, 32'h0000_0002);
    ahb(1'b1, `BCH_OFS_CTRL, 32'h0010_1501);
    // Every job kind; the power meter asks again at each of three points
    for (int k = 0; k < 4; k++) begin
      slow <= k[0];
      ahb(1'b1, `BCH_OFS_JOB, 32'h0000_0300 | k);
      for (int j = 0; j < (k == 2 ? 3 : 1); j++) begin
        poll();
        serve(k[1:0], 1'b1, 8'h15);
        ahb(1'b0, `BCH_OFS_ESR, 32'h0000_0000);
        chk(rd, (k == 2 && j < 2) ? 32'h0000_0002 : 32'h0000_0000);
      end
    end
    // Front panel request
    @(posedge clk);
    fpj <= `BCH_JOB_DISC;
    fpr <= 1'b1;
    @(posedge clk);
    fpr <= 1'b0;
    poll();
    serve(`BCH_JOB_DISC, 1'b1, 8'h15);
    // Unrequested grant goes straight back, to a moved controller address
    ahb(1'b1, `BCH_OFS_CTRL, 32'h0010_0701);
    serve(2'h0, 1'b0, 8'h07);
    // Talker/listener mode keeps control
    ahb(1'b1, `BCH_OFS_CTRL, 32'h0010_0700);
    r0 = ret_n;
    grant();
    repeat (20) @(posedge clk);
    chk(cact, 1'b1);
    chk(ret_n - r0, 32'h0000_0000);
    report_and_stop();
  end
endmodule : test_bch_handoff
